// >>> src/freq_error_estimator_consts.vh
// Constants for the receiver control and frequency error estimator block.
`ifndef FREQ_ERROR_ESTIMATOR_CONSTS_VH
`define FREQ_ERROR_ESTIMATOR_CONSTS_VH

// ==========================================================================
// Register addresses (7-bit).
`define ADDR_MAIN_CTRL 7'h00
`define ADDR_RX_OPTION 7'h01
`define ADDR_FILT_DIV 7'h08
`define ADDR_EST_CTRL 7'h15
`define ADDR_EST_RESULT 7'h16

// ==========================================================================
// Field positions.
`define BIT_AMP_BYPASS 7
`define BIT_MODE_HI 2
`define BIT_MODE_LO 1
`define BIT_SIGNAL_STRENGTH_EN 3
`define BIT_PREFILTER_HI 1
`define BIT_PREFILTER_LO 0
`define BIT_EST_WINDOW_HI 3
`define BIT_EST_WINDOW_LO 2
`define BIT_EST_MODE_HI 1
`define BIT_EST_MODE_LO 0

// ==========================================================================
// Codes and masks.
`define OP_MODE_RECEIVE 2'h2
`define EST_MODE_COUNT 2'h3
`define RX_OPTION_MASK 8'hCF
`define FILT_DIV_FIXED 8'hC0
`define EST_CTRL_MASK 8'h0F
`define WINDOW_BASE 7'h08

// ==========================================================================
// Reset values.
`define RST_MAIN_CTRL 8'h00
`define RST_RX_OPTION 8'h00
`define RST_FILT_DIV 6'h01
`define RST_EST_CTRL 4'h0

// ==========================================================================
// Serial frame layout: 7 address bits, 1 read flag, 8 data bits.
`define FRAME_HDR_BITS 5'h08
`define FRAME_BITS 5'h10

`endif

// >>> src/filter_clock_gen.v
// Channel filter clock divider producing two non-overlapping phases.
`timescale 1ns/1ps
module filter_clock_gen (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Divider setting
  input wire [5:0] filter_clock_divider,
  // Filter clock phases
  output reg filter_phase_a_r,
  output reg filter_phase_b_r
);

  // ========================================================================
  // Prescaler and quarter counter.
  reg [5:0] pre_cnt_r;
  reg [1:0] quarter_r;
  wire [5:0] div_eff;
  wire pre_tick;

  // A zero divider would stall the filter, so it is run as a divide by one.
  assign div_eff = (filter_clock_divider == 6'h00) ? 6'h01 :
                   filter_clock_divider;
  assign pre_tick = (pre_cnt_r >= div_eff - 6'h01);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_cnt_r <= 6'h00;
      quarter_r <= 2'h0;
      filter_phase_a_r <= 1'b0;
      filter_phase_b_r <= 1'b0;
    end else begin
      if (pre_tick) begin
        pre_cnt_r <= 6'h00;
        quarter_r <= quarter_r + 2'h1;
      end else begin
        pre_cnt_r <= pre_cnt_r + 6'h01;
      end
      // Phases are half a period apart with an idle quarter between them,
      // which keeps them non-overlapping at every divider setting.
      filter_phase_a_r <= (quarter_r == 2'h0);
      filter_phase_b_r <= (quarter_r == 2'h2);
    end
  end

endmodule

// >>> src/receiver_freq_error_estimator.v
// Receiver control registers, demodulator decision and error estimator.
`timescale 1ns/1ps
`include "freq_error_estimator_consts.vh"
module receiver_freq_error_estimator (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Serial programming port
  input wire prog_sel,
  input wire prog_clk,
  input wire prog_data_in,
  output reg prog_data_out_r,
  output reg prog_data_oe_r,
  // Limiter outputs and symbol timing
  input wire i_chan,
  input wire q_chan,
  input wire symbol_tick,
  // Analog controls
  output reg amp_bypass_r,
  output reg [1:0] prefilter_cutoff_sel_r,
  output reg signal_strength_enable_r,
  output wire filter_phase_a,
  output wire filter_phase_b,
  // Receive data
  output reg rx_data_pin_r,
  output reg rx_data_oe_r,
  output reg high_tone_pulse_r,
  output reg low_tone_pulse_r
);

  // ========================================================================
  // Helpers.
  function [6:0] window_len;
    input [1:0] sel;
    begin
      window_len = `WINDOW_BASE << sel;
    end
  endfunction

  // ========================================================================
  // Register state.
  reg [7:0] main_ctrl_r;
  reg [7:0] rx_option_r;
  reg [5:0] filter_clock_divider_r;
  reg [3:0] est_ctrl_r;
  reg [7:0] freq_error_count_r;
  reg [6:0] sym_cnt_r;
  reg est_done_r;

  // ========================================================================
  // Serial port framing.
  reg prog_clk_q_r;
  reg [4:0] bit_cnt_r;
  reg [15:0] shift_r;
  reg [7:0] tx_shift_r;
  reg rd_frame_r;
  wire clk_rise;
  wire clk_fall;
  wire [15:0] shift_nxt;
  wire write_commit;
  wire [6:0] frame_addr;
  reg [7:0] read_data;

  assign clk_rise = prog_sel & prog_clk & ~prog_clk_q_r;
  assign clk_fall = prog_sel & ~prog_clk & prog_clk_q_r;
  assign shift_nxt = {shift_r[14:0], prog_data_in};
  // The sixteenth rising edge of a write frame commits the data byte.
  assign write_commit = clk_rise & (bit_cnt_r == `FRAME_BITS - 5'h01) &
                        ~shift_r[7];
  assign frame_addr = rd_frame_r ? shift_r[7:1] : shift_r[14:8];

  always @* begin
    case (frame_addr)
      `ADDR_MAIN_CTRL: read_data = main_ctrl_r;
      `ADDR_RX_OPTION: read_data = rx_option_r & `RX_OPTION_MASK;
      `ADDR_FILT_DIV: read_data = `FILT_DIV_FIXED |
                                  {2'h0, filter_clock_divider_r};
      `ADDR_EST_CTRL: read_data = {4'h0, est_ctrl_r};
      `ADDR_EST_RESULT: read_data = freq_error_count_r;
      default: read_data = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_clk_q_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      tx_shift_r <= 8'h00;
      rd_frame_r <= 1'b0;
      prog_data_out_r <= 1'b0;
      prog_data_oe_r <= 1'b0;
    end else begin
      prog_clk_q_r <= prog_clk;
      if (!prog_sel) begin
        bit_cnt_r <= 5'h00;
        rd_frame_r <= 1'b0;
        prog_data_oe_r <= 1'b0;
      end else begin
        if (clk_rise && bit_cnt_r != `FRAME_BITS) begin
          shift_r <= shift_nxt;
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == `FRAME_HDR_BITS - 5'h01) begin
            rd_frame_r <= prog_data_in;
          end
        end
        // Read data changes on falling edges so the host samples it
        // cleanly on the following rising edge.
        if (clk_fall && rd_frame_r) begin
          if (bit_cnt_r == `FRAME_HDR_BITS) begin
            prog_data_out_r <= read_data[7];
            tx_shift_r <= {read_data[6:0], 1'b0};
            prog_data_oe_r <= 1'b1;
          end else if (bit_cnt_r == `FRAME_BITS) begin
            prog_data_oe_r <= 1'b0;
          end else begin
            prog_data_out_r <= tx_shift_r[7];
            tx_shift_r <= {tx_shift_r[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ========================================================================
  // Writable registers and their outputs.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_ctrl_r <= `RST_MAIN_CTRL;
      rx_option_r <= `RST_RX_OPTION;
      filter_clock_divider_r <= `RST_FILT_DIV;
      est_ctrl_r <= `RST_EST_CTRL;
      amp_bypass_r <= 1'b0;
      prefilter_cutoff_sel_r <= 2'h0;
      signal_strength_enable_r <= 1'b0;
    end else begin
      if (write_commit) begin
        case (shift_r[14:8])
          `ADDR_MAIN_CTRL: main_ctrl_r <= shift_nxt[7:0];
          `ADDR_RX_OPTION: rx_option_r <= shift_nxt[7:0] & `RX_OPTION_MASK;
          `ADDR_FILT_DIV: filter_clock_divider_r <= shift_nxt[5:0];
          `ADDR_EST_CTRL: est_ctrl_r <= shift_nxt[3:0];
          default: ;
        endcase
      end
      amp_bypass_r <= main_ctrl_r[`BIT_AMP_BYPASS];
      prefilter_cutoff_sel_r <= {rx_option_r[`BIT_PREFILTER_HI],
                                 rx_option_r[`BIT_PREFILTER_LO]};
      signal_strength_enable_r <= rx_option_r[`BIT_SIGNAL_STRENGTH_EN];
    end
  end

  filter_clock_gen u_filter_clock_gen (
    .clk_sys(clk_sys),
    .rst(rst),
    .filter_clock_divider(filter_clock_divider_r),
    .filter_phase_a_r(filter_phase_a),
    .filter_phase_b_r(filter_phase_b)
  );

  // ========================================================================
  // Demodulator decision.
  reg i_q_r;
  wire receiving;
  wire i_rise;

  assign receiving = ({main_ctrl_r[`BIT_MODE_HI], main_ctrl_r[`BIT_MODE_LO]}
                      == `OP_MODE_RECEIVE);
  assign i_rise = i_chan & ~i_q_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      i_q_r <= 1'b0;
      rx_data_pin_r <= 1'b0;
      rx_data_oe_r <= 1'b0;
      high_tone_pulse_r <= 1'b0;
      low_tone_pulse_r <= 1'b0;
    end else begin
      i_q_r <= i_chan;
      rx_data_oe_r <= receiving;
      // Quadrature already high when I rises means I lags Q.
      high_tone_pulse_r <= receiving & i_rise & q_chan;
      low_tone_pulse_r <= receiving & i_rise & ~q_chan;
      if (receiving && i_rise) begin
        rx_data_pin_r <= q_chan;
      end
    end
  end

  // ========================================================================
  // Frequency error estimator.
  wire est_run;
  wire [1:0] est_win;

  assign est_win = {est_ctrl_r[`BIT_EST_WINDOW_HI],
                    est_ctrl_r[`BIT_EST_WINDOW_LO]};
  assign est_run = ({est_ctrl_r[`BIT_EST_MODE_HI],
                     est_ctrl_r[`BIT_EST_MODE_LO]} == `EST_MODE_COUNT) &
                   receiving & ~est_done_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      freq_error_count_r <= 8'h00;
      sym_cnt_r <= 7'h00;
      est_done_r <= 1'b0;
    end else if (write_commit) begin
      freq_error_count_r <= 8'h00;
      sym_cnt_r <= 7'h00;
      est_done_r <= 1'b0;
    end else if (est_run) begin
      // Plain 8-bit wrap: going past +127 reads back as negative.
      if (high_tone_pulse_r && !low_tone_pulse_r) begin
        freq_error_count_r <= freq_error_count_r + 8'h01;
      end else if (low_tone_pulse_r && !high_tone_pulse_r) begin
        freq_error_count_r <= freq_error_count_r - 8'h01;
      end
      if (symbol_tick) begin
        sym_cnt_r <= sym_cnt_r + 7'h01;
        if (sym_cnt_r + 7'h01 == window_len(est_win)) begin
          est_done_r <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> tb/rx_monitor.sv
// Assertion checker on the receiver control block ports.
`timescale 1ns/1ps
module rx_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Watched ports
  input wire prog_sel,
  input wire prog_data_oe_r,
  input wire i_chan,
  input wire q_chan,
  input wire rx_data_oe_r,
  input wire rx_data_pin_r,
  input wire high_tone_pulse_r,
  input wire low_tone_pulse_r,
  input wire filter_phase_a,
  input wire filter_phase_b
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Demodulator decision and pulses.
  chk_high_once: assert property (high_tone_pulse_r |=> !high_tone_pulse_r)
    else $error("high pulse too long");
  chk_pulse_excl: assert property (!(high_tone_pulse_r && low_tone_pulse_r))
    else $error("both pulses at once");
  chk_high_data: assert property (high_tone_pulse_r |-> rx_data_pin_r)
    else $error("high pulse with data zero");
  chk_low_data: assert property (low_tone_pulse_r |-> !rx_data_pin_r)
    else $error("low pulse with data one");
  chk_high_cause: assert property ($rose(i_chan) && q_chan && rx_data_oe_r
    |-> ##[1:2] high_tone_pulse_r) else $error("lag gave no high pulse");
  chk_low_cause: assert property ($rose(i_chan) && !q_chan && rx_data_oe_r
    |-> ##[1:2] low_tone_pulse_r) else $error("lead gave no low pulse");
  // Two idle cycles cover a decision launched in the last receive cycle.
  chk_rx_quiet: assert property (!rx_data_oe_r [*2]
    |-> !high_tone_pulse_r && !low_tone_pulse_r) else $error("pulse off rx");
  // ==========================================================
  // Filter clock and serial port.
  chk_phase_excl: assert property (!(filter_phase_a && filter_phase_b))
    else $error("filter phases overlap");
  chk_oe_idle: assert property (!prog_sel [*3] |-> !prog_data_oe_r)
    else $error("read data driven outside frame");
endmodule
bind receiver_freq_error_estimator rx_monitor rx_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .prog_sel(prog_sel),
  .prog_data_oe_r(prog_data_oe_r), .i_chan(i_chan), .q_chan(q_chan),
  .rx_data_oe_r(rx_data_oe_r), .rx_data_pin_r(rx_data_pin_r),
  .high_tone_pulse_r(high_tone_pulse_r), .low_tone_pulse_r(low_tone_pulse_r),
  .filter_phase_a(filter_phase_a), .filter_phase_b(filter_phase_b));

// >>> tb/host_model.sv
// Host model driving the serial programming port.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire clk_sys,
  // Serial port
  output reg prog_sel,
  output reg prog_clk,
  output reg prog_data_in,
  input wire prog_data_out_r,
  input wire prog_data_oe_r
);
  initial begin
    prog_sel = 1'b0;
    prog_clk = 1'b0;
    prog_data_in = 1'b0;
  end
  // ==========================================================
  // One frame: address, read flag, data, MSB first.
  task xfer(input [6:0] a, input rd, input [7:0] wd, output [7:0] q);
    reg [15:0] f;
    integer i;
    begin
      f = {a, rd, wd};
      q = 8'h00;
      @(posedge clk_sys);
      prog_sel <= 1'b1;
      for (i = 15; i >= 0; i = i - 1) begin
        @(posedge clk_sys);
        prog_clk <= 1'b0;
        prog_data_in <= f[i];
        repeat (3) @(posedge clk_sys);
        // A released line reads back inverted, so a missing enable shows.
        if (i < 8) q[i] = prog_data_oe_r ? prog_data_out_r : ~prog_data_out_r;
        prog_clk <= 1'b1;
        repeat (2) @(posedge clk_sys);
      end
      prog_clk <= 1'b0;
      prog_sel <= 1'b0;
      // Idle data toggles so a stale level can never pass for a bit.
      prog_data_in <= ~prog_data_in;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // The offset is the rate over four times the window times the signed
  // result, so its sign alone tells the host which way to pull the
  // reference oscillator.
  function tune_up(input [7:0] fee);
    begin
      tune_up = (fee != 8'h00) && !fee[7];
    end
  endfunction
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the receiver control block.
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg rst, i_chan, q_chan, symbol_tick;
  wire prog_sel, prog_clk, prog_data_in, prog_data_out_r, prog_data_oe_r;
  wire amp_bypass_r, signal_strength_enable_r, rx_data_pin_r, rx_data_oe_r;
  wire filter_phase_a, filter_phase_b, high_tone_pulse_r, low_tone_pulse_r;
  wire [1:0] prefilter_cutoff_sel_r;
  integer fails, checks;
  always #5 clk_sys = ~clk_sys;
  host_model host_model_i (.clk_sys(clk_sys), .prog_sel(prog_sel),
    .prog_clk(prog_clk), .prog_data_in(prog_data_in),
    .prog_data_out_r(prog_data_out_r), .prog_data_oe_r(prog_data_oe_r));
  receiver_freq_error_estimator receiver_freq_error_estimator_i (
    .clk_sys(clk_sys), .rst(rst), .prog_sel(prog_sel), .prog_clk(prog_clk),
    .prog_data_in(prog_data_in), .prog_data_out_r(prog_data_out_r),
    .prog_data_oe_r(prog_data_oe_r), .i_chan(i_chan), .q_chan(q_chan),
    .symbol_tick(symbol_tick), .amp_bypass_r(amp_bypass_r),
    .prefilter_cutoff_sel_r(prefilter_cutoff_sel_r),
    .signal_strength_enable_r(signal_strength_enable_r),
    .filter_phase_a(filter_phase_a), .filter_phase_b(filter_phase_b),
    .rx_data_pin_r(rx_data_pin_r), .rx_data_oe_r(rx_data_oe_r),
    .high_tone_pulse_r(high_tone_pulse_r), .low_tone_pulse_r(low_tone_pulse_r));
  // ==========================================================
  // Shared helpers.
  task chk(input [7:0] got, input [7:0] ex);
    begin
      checks = checks + 1;
      if (got !== ex) begin
        fails = fails + 1;
        $display("BAD %0t got %h exp %h", $time, got, ex);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    reg [7:0] q;
    host_model_i.xfer(a, 1'b0, d, q);
  endtask
  task rd(input [6:0] a, input [7:0] ex);
    reg [7:0] q;
    begin
      host_model_i.xfer(a, 1'b1, 8'h00, q);
      chk(q, ex);
    end
  endtask
  task tone(input q);
    begin
      q_chan <= q;
      i_chan <= 1'b0;
      repeat (2) @(posedge clk_sys);
      i_chan <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(rx_data_pin_r, q);
    end
  endtask
  // The expected value includes the tone sent just before the last symbol.
  task est(input [7:0] ctl, input [3:0] nh, input [3:0] nl, input [7:0] ex);
    integer k;
    reg [7:0] q;
    begin
      wr(7'h15, ctl);
      for (k = 0; k < nh; k = k + 1) tone(1'b1);
      for (k = 0; k < nl; k = k + 1) tone(1'b0);
      for (k = 1; k < (8 << ctl[3:2]); k = k + 1) begin
        symbol_tick <= 1'b1;
        @(posedge clk_sys);
        symbol_tick <= 1'b0;
        @(posedge clk_sys);
      end
      tone(1'b1);
      symbol_tick <= 1'b1;
      @(posedge clk_sys);
      symbol_tick <= 1'b0;
      tone(1'b1);
      host_model_i.xfer(7'h16, 1'b1, 8'h00, q);
      chk(q, ex);
      chk(host_model_i.tune_up(q), ex > 8'h00 && ex < 8'h80);
      rd(7'h15, ctl & 8'h0F);
    end
  endtask
  // ==========================================================
  // Scenarios.
  task t_reset;
    begin
      rd(7'h00, 8'h00);
      rd(7'h01, 8'h00);
      rd(7'h08, 8'hC1);
      rd(7'h15, 8'h00);
      rd(7'h16, 8'h00);
    end
  endtask
  task t_controls;
    integer k;
    begin
      wr(7'h00, 8'h84);
      chk(amp_bypass_r, 1'b1);
      chk(rx_data_oe_r, 1'b1);
      wr(7'h00, 8'h04);
      chk(amp_bypass_r, 1'b0);
      for (k = 0; k < 4; k = k + 1) begin
        wr(7'h01, k[7:0] | 8'h08);
        chk(prefilter_cutoff_sel_r, k[7:0]);
      end
      chk(signal_strength_enable_r, 1'b1);
      wr(7'h01, 8'hFF);
      rd(7'h01, 8'hCF);
      wr(7'h7F, 8'h5A);
      rd(7'h7F, 8'h00);
    end
  endtask
  task t_filter;
    integer n, m;
    begin
      wr(7'h08, 8'h02);
      rd(7'h08, 8'hC2);
      n = 0;
      m = 0;
      while (!filter_phase_a && m < 99) begin
        @(posedge clk_sys);
        m = m + 1;
      end
      m = 0;
      while (filter_phase_a && n < 99) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      while (!filter_phase_a && m < 99) begin
        @(posedge clk_sys);
        m = m + 1;
      end
      chk(n[7:0], 8'h02);
      m = n + m;
      chk(m[7:0], 8'h08);
      n = 0;
      while (!filter_phase_b && n < 99) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      chk(n[7:0], 8'h04);
    end
  endtask
  // Small counts keep each window inside the signed byte.
  task t_estimate;
    begin
      est(8'h03, 4'h3, 4'h0, 8'h04);
      est(8'h07, 4'h0, 4'h3, 8'hFE);
      est(8'h0B, 4'h4, 4'h1, 8'h04);
      est(8'h0F, 4'h1, 4'h0, 8'h02);
      est(8'h00, 4'h2, 4'h0, 8'h00);
    end
  endtask
  // Outside receive a leading tone must neither move the data pin nor count.
  task t_idle;
    begin
      wr(7'h00, 8'h02);
      chk(rx_data_oe_r, 1'b0);
      wr(7'h15, 8'h03);
      q_chan <= 1'b0;
      i_chan <= 1'b0;
      repeat (2) @(posedge clk_sys);
      i_chan <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(rx_data_pin_r, 1'b1);
      rd(7'h16, 8'h00);
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails = fails + 1;
    conclude;
  end
  initial begin
    rst = 1'b1;
    i_chan = 1'b0;
    q_chan = 1'b0;
    symbol_tick = 1'b0;
    fails = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_controls;
    t_filter;
    t_estimate;
    t_idle;
    conclude;
  end
endmodule
